// [design/mpt_cfg.svh]
// Constants of the modulo periodic timer: offsets, fields, reset values
// Assumes an 8-bit register port with byte offsets as printed
// Function
// - 16-bit up counter, free or modulo
// - Counter reads never disturb counting
// - Prescaler divides by 1 to 64
// - Match sets flag, restarts at zero
// - Flag clears by read then zero write
// - Overflow between steps keeps flag set
// - Interrupt request when enabled and flagged
// - Halt bit holds counter, set at reset
// - Counter reset clears counter and prescaler
// - Halt with counter reset holds zero
// - High read latches low byte
// - Reset clears counter bytes
// - Modulo high write inhibits flag
// - Reset sets modulo bytes to ones
// - Wait mode keeps counting, wakes CPU
// - Stop mode freezes timer, keeps state
// - Break halts the counter
// - Break clears flag only when enabled
// - Break latched low byte is kept
// - Reset clears prescaler select
`ifndef MPT_CFG_SVH
`define MPT_CFG_SVH
`define MPT_ADDR_STATUS_CONTROL 8'h4b
`define MPT_ADDR_COUNT_HIGH     8'h4c
`define MPT_ADDR_COUNT_LOW      8'h4d
`define MPT_ADDR_MODULO_HIGH    8'h4e
`define MPT_ADDR_MODULO_LOW     8'h4f
`define MPT_BIT_FLAG            7
`define MPT_BIT_ENABLE          6
`define MPT_BIT_HALT            5
`define MPT_BIT_CNT_RESET       4
`define MPT_DIV_LSB             0
`define MPT_DIV_MSB             2
`define MPT_RST_MODULO          16'hffff
`define MPT_RST_COUNT           16'h0000
`define MPT_RST_DIV             3'h0
`define MPT_DIV_MAX             3'h6
`endif

// [design/mpt_pkg.sv]
// Types of the modulo periodic timer
// Assumes the config header is compiled alongside
package mpt_pkg;
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mpt_bus_req_t;
endpackage : mpt_pkg

// [design/mpt_timer.sv]
// Modulo periodic timer core with byte register port
// Assumes one bus clock; mode inputs are synchronous to it
`timescale 1ns/1ns
`include "mpt_cfg.svh"
module mpt_timer
   import mpt_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // System modes
   input  wire logic       wait_mode,
   input  wire logic       stop_mode,
   input  wire logic       break_active,
   input  wire logic       break_clear_enable,
   // Interrupt request
   output logic            irq_q
);
   // ==========================================================
   // Bus decode
   mpt_bus_req_t req;
   assign req = '{wr: reg_wr & ~wait_mode, rd: reg_rd & ~wait_mode,
                  addr: reg_addr, wdata: reg_wdata};
   logic wr_sc, wr_mh, wr_ml, rd_sc, rd_ch, rd_cl;
   assign wr_sc = req.wr && req.addr == `MPT_ADDR_STATUS_CONTROL;
   assign wr_mh = req.wr && req.addr == `MPT_ADDR_MODULO_HIGH;
   assign wr_ml = req.wr && req.addr == `MPT_ADDR_MODULO_LOW;
   assign rd_sc = req.rd && req.addr == `MPT_ADDR_STATUS_CONTROL;
   assign rd_ch = req.rd && req.addr == `MPT_ADDR_COUNT_HIGH;
   assign rd_cl = req.rd && req.addr == `MPT_ADDR_COUNT_LOW;

   // ==========================================================
   // Control state
   logic [15:0] count_q, modulo_q;
   logic [5:0]  presc_q;
   logic [2:0]  div_q;
   logic        halt_q, enable_q, flag_q, armed_q, inhibit_q;
   logic [7:0]  low_hold_q;
   logic        hold_full_q;
   logic        cnt_reset;
   assign cnt_reset = wr_sc & req.wdata[`MPT_BIT_CNT_RESET];

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         halt_q   <= 1'b1;
         enable_q <= 1'b0;
         div_q    <= `MPT_RST_DIV;
      end
      else if (wr_sc)
      begin
         halt_q   <= req.wdata[`MPT_BIT_HALT];
         enable_q <= req.wdata[`MPT_BIT_ENABLE];
         div_q    <= req.wdata[`MPT_DIV_MSB:`MPT_DIV_LSB];
      end
   end

   // ==========================================================
   // Prescaler and counter
   logic tick;
   logic run;
   logic match;
   // Codes above six divide by 64
   always_comb
   begin
      if (div_q >= `MPT_DIV_MAX)
         tick = &presc_q;
      else
         tick = (presc_q & ((6'h01 << div_q) - 6'h01)) == ((6'h01 << div_q) - 6'h01);
   end
   // Wait keeps counting; stop freezes; break halts
   assign run   = ~halt_q & ~stop_mode & ~break_active;
   assign match = run & tick & (count_q == modulo_q);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count_q <= `MPT_RST_COUNT;
         presc_q <= 6'h00;
      end
      // Clears counter and prescaler; halt keeps zero
      else if (cnt_reset)
      begin
         count_q <= `MPT_RST_COUNT;
         presc_q <= 6'h00;
      end
      else if (run)
      begin
         presc_q <= presc_q + 6'h01;
         if (tick)
            count_q <= match ? `MPT_RST_COUNT : count_q + 16'h0001;
      end
   end

   // ==========================================================
   // Modulo registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         modulo_q  <= `MPT_RST_MODULO;
         inhibit_q <= 1'b0;
      end
      else
      begin
         if (wr_mh)
            modulo_q[15:8] <= req.wdata;
         if (wr_ml)
            modulo_q[7:0] <= req.wdata;
         if (wr_ml)
            inhibit_q <= 1'b0;
         else if (wr_mh)
            inhibit_q <= 1'b1;
      end
   end

   // ==========================================================
   // Overflow flag
   logic prot;
   logic clear_ok;
   assign prot     = break_active & ~break_clear_enable;
   assign clear_ok = wr_sc & ~req.wdata[`MPT_BIT_FLAG] & armed_q & ~prot;

   // Next flag and enable, so the request tracks them without lag
   logic flag_set;
   logic flag_d;
   logic enable_d;
   assign flag_set = match & ~inhibit_q;
   // Set wins over a clear in the same cycle
   assign flag_d   = flag_set | (flag_q & ~clear_ok);
   assign enable_d = wr_sc ? req.wdata[`MPT_BIT_ENABLE] : enable_q;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_q  <= 1'b0;
         armed_q <= 1'b0;
      end
      else
      begin
         if (match & ~inhibit_q)
            flag_q <= 1'b1;
         else if (clear_ok)
            flag_q <= 1'b0;
         if (match & ~inhibit_q)
            armed_q <= 1'b0;
         else if (rd_sc & flag_q & ~prot)
            armed_q <= 1'b1;
         else if (clear_ok)
            armed_q <= 1'b0;
      end
   end

   // Level request while enabled and flagged; wakes from wait
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_q <= 1'b0;
      else
         irq_q <= enable_d & flag_d;
   end

   // ==========================================================
   // Low byte latch and read data
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         low_hold_q  <= 8'h00;
         hold_full_q <= 1'b0;
      end
      // Latch on high read; kept after break
      else if (rd_ch & ~hold_full_q)
      begin
         low_hold_q  <= count_q[7:0];
         hold_full_q <= 1'b1;
      end
      else if (rd_cl)
         hold_full_q <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (rd_sc)
         reg_rdata <= {flag_q, enable_q, halt_q, 1'b0, 1'b0, div_q};
      else if (rd_ch)
         reg_rdata <= count_q[15:8];
      else if (rd_cl)
         reg_rdata <= hold_full_q ? low_hold_q : count_q[7:0];
      else if (req.rd && req.addr == `MPT_ADDR_MODULO_HIGH)
         reg_rdata <= modulo_q[15:8];
      else if (req.rd && req.addr == `MPT_ADDR_MODULO_LOW)
         reg_rdata <= modulo_q[7:0];
      else
         reg_rdata <= 8'h00;
   end
endmodule : mpt_timer

// [dv/mpt_checker.sv]
// Assertions on the timer register port
// Assumes a bind onto mpt_timer
`timescale 1ns/1ns
module mpt_checker
(
   // Watched ports
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       wait_mode,
   input wire logic       irq_q
);
   // ======
   // Shadow state
   logic [7:0] mh_q, ml_q;
   logic       arm_q, hz_q;
   wire        w = reg_wr & ~wait_mode;
   wire        r = reg_rd & ~wait_mode;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn) {mh_q, ml_q} <= 16'hffff;
      else if (w && reg_addr == 8'h4e) mh_q <= reg_wdata;
      else if (w && reg_addr == 8'h4f) ml_q <= reg_wdata;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn) arm_q <= 1'b0;
      else if (w && reg_addr[7:1] == 7'h27) arm_q <= ~reg_addr[0];
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn) hz_q <= 1'b0;
      else if (w && reg_addr == 8'h4b) hz_q <= reg_wdata[5] & (reg_wdata[4] | hz_q);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   irq_tracks_a: assert property ($past(r && reg_addr == 8'h4b)
      |-> irq_q == (reg_rdata[6] & (reg_rdata[7] | irq_q))) else $error("irq mismatch");
   rst_bit_a: assert property ($past(r && reg_addr == 8'h4b)
      |-> reg_rdata[4:3] == 2'b00) else $error("reset bit read");
   wait_read_a: assert property (wait_mode && reg_rd
      |=> reg_rdata == 8'h00) else $error("wait read answered");
   irq_fall_a: assert property ($fell(irq_q)
      |-> $past(w && reg_addr == 8'h4b)) else $error("irq fell alone");
   inhibit_a: assert property ($rose(irq_q)
      |-> !$past(arm_q)) else $error("irq while inhibited");
   mod_high_a: assert property ($past(r && reg_addr == 8'h4e)
      |-> reg_rdata == $past(mh_q)) else $error("modulo high");
   mod_low_a: assert property ($past(r && reg_addr == 8'h4f)
      |-> reg_rdata == $past(ml_q)) else $error("modulo low");
   hold_zero_a: assert property ($past(r && reg_addr == 8'h4c && hz_q)
      |-> reg_rdata == 8'h00) else $error("count not held");
   cover property ($rose(irq_q));
   cover property ($fell(irq_q));
   cover property (w && arm_q && reg_addr == 8'h4f);
endmodule : mpt_checker

// [dv/mpt_cpu.sv]
// Bus master model standing for the CPU core
// Assumes one strobe cycle per access
`timescale 1ns/1ns
module mpt_cpu
(
   // Clock
   input  wire logic       core_clk,
   // Register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
   // ======
   // One access, then a released bus
   task acc(input logic wn, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= wn;
      reg_rd    <= ~wn;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : acc
endmodule : mpt_cpu

// [dv/test_modulo_periodic_interrupt_timer.sv]
// Self-checking bench of the modulo timer
// Assumes mpt_cpu drives the register port
`timescale 1ns/1ns
module test_modulo_periodic_interrupt_timer;
   logic        core_clk, resetn, wait_mode, stop_mode, break_active, reg_wr, reg_rd, irq_q;
   logic        break_clear_enable = 1'b0;
   logic        rd_d = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, m;
   logic [3:0]  d;
   logic [15:0] q [$];
   int          n_errors = 0, checks = 0, cyc = 0, t1, t2, seed = 54634;
   logic [7:0]  ra [6] = '{8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h4a};
   logic [7:0]  rv [6] = '{8'h20, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
   mpt_timer dut (.*);
   mpt_cpu   cpu (.*);
   always #20 core_clk = ~core_clk;
   task check(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [7:0] v);
      cpu.acc(1'b1, a, v);
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e);
      q.push_back({k, e});
      cpu.acc(1'b0, a, 8'h00);
   endtask : rd
   task rise(output int t);
      @(posedge irq_q);
      @(negedge core_clk);
      t = cyc;
   endtask : rise
   task summarize;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // ======
   // Read data watcher and time limit
   always @(posedge core_clk)
   begin : watch
      logic [15:0] e;
      e = rd_d ? q.pop_front() : 16'h0000;
      if (rd_d) check("rdata", {8'h00, reg_rdata & e[15:8]}, {8'h00, e[7:0]});
      rd_d <= reg_rd;
      cyc  <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize();
      end
   end
   initial
   begin
      core_clk = 1'b0;
      resetn = 1'b0;
      {wait_mode, stop_mode, break_active} = 3'h0;
      m = 8'h08 + 8'($random(seed) & 7);
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      wr(8'h4c, 8'hff);
      foreach (ra[i]) rd(ra[i], 8'hff, rv[i]);
      $display("test reset done");
      wr(8'h4b, 8'h30);
      for (d = 0; d < 8; d++)
      begin
         wr(8'h4e, 8'h00);
         wr(8'h4f, m);
         wr(8'h4b, {5'h08, d[2:0]});
         rise(t1);
         rd(8'h4b, 8'hff, {5'h18, d[2:0]});
         wr(8'h4b, {5'h08, d[2:0]});
         rise(t2);
         check("period", 16'(t2 - t1), 16'(m + 1) << (d > 6 ? 6 : d));
         rd(8'h4b, 8'h80, 8'h80);
         wr(8'h4b, 8'h30);
      end
      $display("test divider done");
      wr(8'h4b, 8'h40);
      rise(t1);
      rd(8'h4b, 8'h80, 8'h80);
      repeat (20) @(posedge core_clk);
      wr(8'h4b, 8'h40);
      rd(8'h4b, 8'h80, 8'h80);
      wr(8'h4b, 8'h70);
      rd(8'h4b, 8'h7f, 8'h60);
      wr(8'h4b, 8'h70);
      rd(8'h4b, 8'hff, 8'h60);
      wr(8'h4b, 8'hf0);
      rd(8'h4b, 8'hff, 8'h60);
      rd(8'h4c, 8'hff, 8'h00);
      rd(8'h4d, 8'hff, 8'h00);
      $display("test flag done");
      stop_mode <= 1'b1;
      wr(8'h4b, 8'h00);
      repeat (9) @(posedge core_clk);
      rd(8'h4b, 8'hff, 8'h00);
      rd(8'h4d, 8'hff, 8'h00);
      stop_mode <= 1'b0;
      break_active <= 1'b1;
      rd(8'h4d, 8'hff, 8'h00);
      break_active <= 1'b0;
      $display("test freeze done");
      wr(8'h4b, 8'h70);
      wr(8'h4e, 8'h00);
      wr(8'h4b, 8'h40);
      repeat (40) @(posedge core_clk);
      rd(8'h4b, 8'h80, 8'h00);
      wr(8'h4f, m);
      repeat (40) @(posedge core_clk);
      rd(8'h4b, 8'h80, 8'h80);
      wait_mode <= 1'b1;
      rd(8'h4b, 8'hff, 8'h00);
      wr(8'h4b, 8'h20);
      wait_mode <= 1'b0;
      rd(8'h4b, 8'h20, 8'h00);
      $display("test modes done");
      repeat (2) @(posedge core_clk);
      check("pending", 16'(q.size()), 16'h0000);
      summarize();
   end
endmodule : test_modulo_periodic_interrupt_timer
bind mpt_timer mpt_checker chk (.*);
